// ---- design/csc_status_pins.sv ----
// status and control pin logic of a single-cell charger
// Operation
// - source-select high gives 500mA default limit, low gives 2.4A
// - once the link is up, the written five-bit limit replaces the default
// - input-good low only inside voltage window, above sleep, limit over 30mA
// - charge-status held low while a charge cycle runs
// - charge-status released when charge is done or charger sleeps
// - charge-status blinks at 1Hz, 50% duty, while suspended by fault
// - charge-status indication stops when the pin function field is off
// - one 256us low pulse on host interrupt on fault or status change
// - charging enabled only with config bit 1 and enable pin low
// - charging suspends while thermistor sense is outside its window
// - a 1s low on switch control leaves ship mode, switch on
// - no input: 16s low turns switch off 250ms then back on
// inputs are synchronous to clk; charge-status given as a drive-low enable, input-good and host interrupt as active-low levels
`timescale 1ns/100ps
`default_nettype none
`include "csc_params.svh"
module csc_status_pins
    import csc_pkg::*;
#(
    parameter int IRQ_CYC   = `CSC_IRQ_PULSE_CYC,
    parameter int BLINK_CYC = `CSC_BLINK_HALF_CYC,
    parameter int SHIP_CYC  = `CSC_SHIP_EXIT_CYC,
    parameter int RST_CYC   = `CSC_SYS_RESET_CYC,
    parameter int OFF_CYC   = `CSC_SW_OFF_CYC
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // pins and analog flags
    input  wire logic        source_select,
    input  wire logic        charge_enable_n,
    input  wire logic        switch_control_n,
    input  wire csc_analog_t analog,
    input  wire logic        ship_mode_req,
    // configuration from the serial link
    input  wire logic        link_up,
    input  wire logic        ilim_write,
    input  wire logic [4:0]  input_current_limit_field,
    input  wire logic [1:0]  status_pin_function_field,
    input  wire logic        charge_config_bit,
    // outputs
    output logic [4:0]       input_current_limit,
    output logic             input_good_n,
    output logic             stat_drive_low,
    output logic             host_irq_n,
    output logic             charge_enable,
    output logic             battery_switch,
    output logic             in_ship_mode
);
    typedef struct packed {
        csc_chg_state_t chg;
        csc_sw_state_t  sw;
        logic           ilim_own;
        logic [4:0]     ilim;
        logic           good_n;
        logic           stat_low;
        logic           blink;
        logic [31:0]    blink_cnt;
        logic [31:0]    low_cnt;
        logic [31:0]    off_cnt;
        logic           chg_en;
        logic           fault_d;
        logic           irq_start;
        logic           bsw;
        logic           ship;
    } csc_state_t;

    csc_state_t st;
    csc_state_t next_st;
    logic       irq_pulse_n;

    function automatic logic [31:0] sat_inc(input logic [31:0] v);
        sat_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h1;
    endfunction

    always_comb begin
        next_st = st;
        next_st.irq_start = 1'b0;
        // current limit select
        if (link_up && ilim_write) begin
            next_st.ilim_own = 1'b1;
            next_st.ilim     = input_current_limit_field;
        end else if (!st.ilim_own) begin
            next_st.ilim = source_select ? `CSC_ILIM_USB_CODE
                                         : `CSC_ILIM_ADAPTOR_CODE;
        end
        next_st.good_n = !(analog.vin_above_uvlo && analog.vin_below_ovl &&
                           analog.vin_above_sleep &&
                           st.ilim > `CSC_ILIM_MIN_CODE);
        next_st.chg_en = charge_config_bit && !charge_enable_n;
        // charge state
        if (!st.chg_en || analog.charge_done || !analog.vin_above_sleep) begin
            next_st.chg = CSC_CHG_IDLE;
        end else if (analog.fault || !analog.therm_in_window) begin
            next_st.chg = CSC_CHG_SUSPEND;
        end else begin
            next_st.chg = CSC_CHG_ACTIVE;
        end
        // blink timebase
        if (st.blink_cnt >= 32'(BLINK_CYC - 1)) begin
            next_st.blink_cnt = 32'h0;
            next_st.blink     = !st.blink;
        end else begin
            next_st.blink_cnt = st.blink_cnt + 32'h1;
        end
        unique case (st.chg)
            CSC_CHG_ACTIVE:  next_st.stat_low = 1'b1;
            CSC_CHG_SUSPEND: next_st.stat_low = st.blink;
            CSC_CHG_IDLE:    next_st.stat_low = 1'b0;
        endcase
        if (status_pin_function_field == `CSC_STAT_FN_OFF) begin
            next_st.stat_low = 1'b0;
        end
        // interrupt on fault or status change
        next_st.fault_d = analog.fault;
        if ((analog.fault && !st.fault_d) || next_st.chg != st.chg) begin
            next_st.irq_start = 1'b1;
        end
        // switch control low-time
        next_st.low_cnt = switch_control_n ? 32'h0 : sat_inc(st.low_cnt);
        unique case (st.sw)
            CSC_SW_ON: begin
                if (ship_mode_req) begin
                    next_st.sw = CSC_SW_SHIP;
                end else if (!analog.vin_above_uvlo &&
                             st.low_cnt >= 32'(RST_CYC - 1)) begin
                    next_st.sw      = CSC_SW_RESET;
                    next_st.off_cnt = 32'h0;
                end
            end
            CSC_SW_SHIP: begin
                if (st.low_cnt >= 32'(SHIP_CYC - 1)) begin
                    next_st.sw = CSC_SW_WAITHI;
                end
            end
            CSC_SW_RESET: begin
                if (st.off_cnt >= 32'(OFF_CYC - 1)) begin
                    next_st.sw = CSC_SW_WAITHI;
                end else begin
                    next_st.off_cnt = st.off_cnt + 32'h1;
                end
            end
            CSC_SW_WAITHI: begin
                if (switch_control_n) begin
                    next_st.sw = CSC_SW_ON;
                end
            end
            default: next_st.sw = CSC_SW_ON;
        endcase
        // switch pins registered from the next switch state
        next_st.bsw  = (next_st.sw == CSC_SW_ON) ||
                       (next_st.sw == CSC_SW_WAITHI);
        next_st.ship = (next_st.sw == CSC_SW_SHIP);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{chg: CSC_CHG_IDLE, sw: CSC_SW_ON, ilim_own: 1'b0,
                    ilim: 5'h00, good_n: 1'b1, stat_low: 1'b0, blink: 1'b0,
                    blink_cnt: 32'h0, low_cnt: 32'h0, off_cnt: 32'h0,
                    chg_en: 1'b0, fault_d: 1'b0, irq_start: 1'b0,
                    bsw: 1'b1, ship: 1'b0};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    csc_pulse_timer #(
        .WIDTH_CYC (IRQ_CYC)
    ) u_irq (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .start   (st.irq_start),
        .pulse_n (irq_pulse_n)
    );

    assign input_current_limit = st.ilim;
    assign input_good_n        = st.good_n;
    assign stat_drive_low      = st.stat_low;
    assign host_irq_n          = irq_pulse_n;
    assign charge_enable       = st.chg_en;
    assign battery_switch      = st.bsw;
    assign in_ship_mode        = st.ship;

    sequence s_reset_entry;
        $changed(st.sw) && st.sw == CSC_SW_RESET;
    endsequence

    a_ilim_default: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !st.ilim_own && !(link_up && ilim_write) && source_select
        |=> st.ilim == `CSC_ILIM_USB_CODE)
        else $error("usb default limit not applied");
    a_ilim_write: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && link_up && ilim_write
        |=> st.ilim == $past(input_current_limit_field))
        else $error("written limit not taken");
    a_good_window: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && !analog.vin_below_ovl |=> input_good_n)
        else $error("input good asserted above overvoltage");
    a_stat_active: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && st.chg == CSC_CHG_ACTIVE &&
        status_pin_function_field != `CSC_STAT_FN_OFF |=> stat_drive_low)
        else $error("status not low while charging");
    a_stat_idle: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && st.chg == CSC_CHG_IDLE |=> !stat_drive_low)
        else $error("status driven while idle");
    a_stat_off: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && status_pin_function_field == `CSC_STAT_FN_OFF
        |=> !stat_drive_low)
        else $error("status driven while function off");
    a_charge_gate: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && charge_enable_n |=> !charge_enable)
        else $error("charge enabled with enable pin high");
    a_therm_susp: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && st.chg_en && !analog.charge_done && analog.vin_above_sleep
        && !analog.therm_in_window |=> st.chg == CSC_CHG_SUSPEND)
        else $error("charge not suspended on thermistor fault");
    a_ship_exit: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && st.sw == CSC_SW_SHIP && st.low_cnt >= 32'(SHIP_CYC - 1)
        |=> battery_switch)
        else $error("ship mode not left after long low");
    a_reset_off: assert property (@(posedge clk) disable iff (sys_rst)
        s_reset_entry |-> !battery_switch)
        else $error("switch not off in reset phase");
endmodule
`default_nettype wire

// ---- pkg/csc_params.svh ----
// timing counts and encodings for the charger status and control pins
// assumes a 100 MHz clock (10 ns period)
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH
`define CSC_CLK_PERIOD_NS      10
`define CSC_IRQ_PULSE_US       256
`define CSC_IRQ_PULSE_CYC      ((`CSC_IRQ_PULSE_US * 1000) / `CSC_CLK_PERIOD_NS)
`define CSC_BLINK_HZ           1
`define CSC_BLINK_HALF_CYC     (1000000000 / (2 * `CSC_BLINK_HZ * `CSC_CLK_PERIOD_NS))
`define CSC_SHIP_EXIT_MS       1000
`define CSC_SHIP_EXIT_CYC      ((`CSC_SHIP_EXIT_MS * 1000000) / `CSC_CLK_PERIOD_NS)
`define CSC_SYS_RESET_MS       16000
`define CSC_SYS_RESET_CYC      ((`CSC_SYS_RESET_MS * 1000000) / `CSC_CLK_PERIOD_NS)
`define CSC_SW_OFF_MS          250
`define CSC_SW_OFF_CYC         ((`CSC_SW_OFF_MS * 1000000) / `CSC_CLK_PERIOD_NS)
`define CSC_ILIM_USB_CODE      5'h04
`define CSC_ILIM_ADAPTOR_CODE  5'h17
`define CSC_ILIM_MIN_CODE      5'h00
`define CSC_STAT_FN_OFF        2'h0
`endif

// ---- pkg/csc_pkg.sv ----
// types for the charger status and control pins
// no surroundings assumed
package csc_pkg;
    typedef enum logic [2:0] {
        CSC_CHG_IDLE    = 3'h1,
        CSC_CHG_ACTIVE  = 3'h2,
        CSC_CHG_SUSPEND = 3'h4
    } csc_chg_state_t;

    typedef enum logic [3:0] {
        CSC_SW_ON     = 4'h1,
        CSC_SW_SHIP   = 4'h2,
        CSC_SW_RESET  = 4'h4,
        CSC_SW_WAITHI = 4'h8
    } csc_sw_state_t;

    typedef struct packed {
        logic vin_above_uvlo;
        logic vin_below_ovl;
        logic vin_above_sleep;
        logic charge_done;
        logic fault;
        logic therm_in_window;
    } csc_analog_t;
endpackage

// ---- design/csc_pulse_timer.sv ----
// one-shot low pulse generator, active-low output
// assumes start is a one-cycle strobe in the clk domain
`timescale 1ns/100ps
`default_nettype none
module csc_pulse_timer
    import csc_pkg::*;
#(
    parameter int WIDTH_CYC = 25600
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // control
    input  wire logic start,
    output logic      pulse_n
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        pulse_n;
    } csc_pt_state_t;

    csc_pt_state_t st;
    csc_pt_state_t next_st;

    always_comb begin
        next_st = st;
        if (start) begin
            next_st.cnt     = 32'(WIDTH_CYC - 1);
            next_st.pulse_n = 1'b0;
        end else if (!st.pulse_n) begin
            if (st.cnt == 32'h0) begin
                next_st.pulse_n = 1'b1;
            end else begin
                next_st.cnt = st.cnt - 32'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{cnt: 32'h0, pulse_n: 1'b1};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign pulse_n = st.pulse_n;

    a_pulse_width: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(st.pulse_n) && clk_en |-> st.cnt == 32'(WIDTH_CYC - 1))
        else $error("interrupt pulse loaded with wrong width");
endmodule
`default_nettype wire

// ---- tb/csc_host_model.sv ----
// host side of the pins: serial link writes and switch control pulses
// assumes the testbench calls its tasks; drives 1ns after each rising edge
`timescale 1ns/100ps
`default_nettype none
module csc_host_model (
    // clock
    input  wire logic       clk,
    // driven pins
    output logic            switch_control_n,
    output logic            link_up,
    output logic            ilim_write,
    output logic [4:0]      input_current_limit_field
);
    initial begin
        switch_control_n = 1'h1;
        link_up = 1'h0;
        ilim_write = 1'h0;
        input_current_limit_field = 5'h00;
    end
    // low pulse of n cycles, pull-up level otherwise
    task automatic pulse(input int n);
        @(posedge clk);
        #1 switch_control_n = 1'h0;
        repeat (n) @(posedge clk);
        #1 switch_control_n = 1'h1;
    endtask
    // one-cycle limit write with link state up or down
    task automatic write_ilim(input logic [4:0] v, input logic up);
        @(posedge clk);
        #1 link_up = up;
        input_current_limit_field = v;
        ilim_write = 1'h1;
        @(posedge clk);
        #1 ilim_write = 1'h0;
        input_current_limit_field = ~v;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench of the charger status and control pins
// assumes short timing parameters; host model drives the link and switch pin
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module testbench
    import csc_pkg::*;
;
    typedef struct packed {
        logic ss, ce_n, cfg;
        csc_analog_t an;
        logic [1:0] fn;
        logic [4:0] ilim;
        logic good_n, ce, stat;
    } csc_row_t;
    logic clk = 1'h0, sys_rst = 1'h1, ss = 1'h1, ce_n = 1'h1, cfg = 1'h0;
    logic ship = 1'h0, sw_n, up, wr, good_n, stat, irq_n, ce, bsw, shipm;
    logic [4:0]  fld, ilim;
    logic [1:0]  fn = 2'h1;
    logic        en = 1'h1;
    csc_analog_t an = 6'h39;
    int err_count = 0, n_checks = 0, w;
    csc_row_t rows [8] = '{
        '{1'h1,1'h0,1'h1,6'h39,2'h1,5'h04,1'h0,1'h1,1'h1},
        '{1'h0,1'h0,1'h1,6'h39,2'h1,5'h17,1'h0,1'h1,1'h1},
        '{1'h0,1'h1,1'h1,6'h39,2'h1,5'h17,1'h0,1'h0,1'h0},
        '{1'h1,1'h0,1'h0,6'h39,2'h1,5'h04,1'h0,1'h0,1'h0},
        '{1'h1,1'h0,1'h1,6'h3D,2'h1,5'h04,1'h0,1'h1,1'h0},
        '{1'h1,1'h0,1'h1,6'h31,2'h1,5'h04,1'h1,1'h1,1'h0},
        '{1'h1,1'h0,1'h1,6'h29,2'h1,5'h04,1'h1,1'h1,1'h1},
        '{1'h1,1'h0,1'h1,6'h39,2'h0,5'h04,1'h0,1'h1,1'h0}};
    always #5 clk = ~clk;
    csc_host_model host (.clk(clk), .switch_control_n(sw_n), .link_up(up),
        .ilim_write(wr), .input_current_limit_field(fld));
    csc_status_pins #(.IRQ_CYC(8), .BLINK_CYC(16), .SHIP_CYC(20),
        .RST_CYC(40), .OFF_CYC(10)) dut (.clk(clk), .sys_rst(sys_rst),
        .clk_en(en), .source_select(ss), .charge_enable_n(ce_n),
        .switch_control_n(sw_n), .analog(an), .ship_mode_req(ship),
        .link_up(up), .ilim_write(wr), .input_current_limit_field(fld),
        .status_pin_function_field(fn), .charge_config_bit(cfg),
        .input_current_limit(ilim), .input_good_n(good_n),
        .stat_drive_low(stat), .host_irq_n(irq_n), .charge_enable(ce),
        .battery_switch(bsw), .in_ship_mode(shipm));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic sig(input int s);
        return s == 0 ? irq_n : s == 1 ? stat : bsw;
    endfunction
    // waits for a change of one output, then counts how long it stands
    task automatic span(input int s, output int n);
        logic v;
        v = sig(s);
        n = 0;
        for (int i = 0; i < 200 && sig(s) === v; i++) tick(1);
        v = sig(s);
        while (sig(s) === v && n < 200) begin
            tick(1);
            n++;
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        tick(10);
        `CHK({ilim, good_n, stat, irq_n, ce, bsw, shipm}, 11'h02A)
        tick(6);
        sys_rst = 1'h0;
        foreach (rows[i]) begin
            {ss, ce_n, cfg, an, fn} = rows[i][18:8];
            tick(6);
            `CHK({ilim, good_n, ce, stat}, rows[i][7:0])
        end
        fn = 2'h1;
        host.write_ilim(5'h0A, 1'h0);
        tick(3);
        `CHK(ilim, 5'h04)
        host.write_ilim(5'h0A, 1'h1);
        ss = 1'h0;
        tick(3);
        `CHK(ilim, 5'h0A)
        host.write_ilim(5'h00, 1'h1);
        tick(3);
        `CHK(good_n, 1'h1)
        host.write_ilim(5'h04, 1'h1);
        tick(12);
        an = 6'h38;
        span(0, w);
        `CHK(w, 8)
        `CHK(ce, 1'h1)
        span(1, w);
        span(1, w);
        `CHK(w, 16)
        span(1, w);
        `CHK(w, 16)
        an = 6'h39;
        ship = 1'h1;
        tick(1);
        ship = 1'h0;
        tick(3);
        `CHK({shipm, bsw}, 2'h2)
        host.pulse(15);
        tick(3);
        `CHK(bsw, 1'h0)
        host.pulse(25);
        tick(3);
        `CHK({shipm, bsw}, 2'h1)
        an = 6'h19;
        fork
            host.pulse(50);
            span(2, w);
        join
        `CHK(w, 10)
        tick(3);
        `CHK(bsw, 1'h1)
        // fault rising while already suspended still interrupts
        an = 6'h38;
        tick(12);
        an = 6'h3A;
        span(0, w);
        `CHK(w, 8)
        // clock enable low freezes the enable gate
        en = 1'h0;
        ce_n = 1'h1;
        tick(3);
        `CHK(ce, 1'h1)
        en = 1'h1;
        tick(3);
        `CHK(ce, 1'h0)
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run;
    end
endmodule
`default_nettype wire
